// ==== rtl/aeg_encoder.sv ====
// Purpose: gray position word, correction, msb invert, load/shift serial port, led alarm
// Assumes: all pins asynchronous to clk; shift clock far slower than clk
// Notes: registers over Avalon-MM, one wait state per access
`timescale 1ns/1ps
`include "aeg_regs.svh"
// Summary of operation
// - interpolator makes fine sine, cosine bits and four interpolated bits
// - interpolated bits appended below the 12-bit coarse/fine gray code
// - upper 12-bit code stays monotonic at speeds up to 12000 RPM
// - correction aligns coarse track switching points to fine sine/cosine bits
// - correction touches only the upper 12 bits, never the interpolated bits
// - correction active while its enable input is high, off while low
// - word leaves the serial output msb first, top coarse bit
// - msb invert request flips the word msb, reversing count direction
// - high level at msb invert input requests the inversion
// - shift/load select high means load mode, low means shift mode
// - in load mode the serial output shows the current word msb
// - in shift mode each shift clock advances one bit to the output
// - serial input level enters the register end while shifting
// - led error flag rises when drive transistor voltage exceeds VDD/2
module aeg_encoder
   import aeg_pkg::*;
#(
   parameter int SW = 12
)
(
   input  wire logic          clk,                    // system clock, 100 MHz
   input  wire logic          rst_n,                  // synchronous reset
   input  wire logic [7:0]    avs_address,            // byte address
   input  wire logic          avs_read,               // read request
   input  wire logic          avs_write,              // write request
   input  wire logic [31:0]   avs_writedata,          // write data
   input  wire logic [3:0]    avs_byteenable,         // byte lanes
   output logic      [31:0]   avs_readdata,           // read data
   output logic               avs_waitrequest,        // stall
   output logic               irq,                    // level interrupt
   input  wire logic [10:0]   coarse_track_bits,      // digitised coarse tracks
   input  wire logic [SW-1:0] sine_channel,           // conditioned sine sample
   input  wire logic [SW-1:0] cosine_channel,         // conditioned cosine sample
   input  wire logic          led_drive_above_half,   // comparator: drive above VDD/2
   input  wire logic          gray_correction_enable, // correction select
   input  wire logic          msb_invert,             // flip msb
   input  wire logic          shift_load_select,      // 1 load, 0 shift
   input  wire logic          shift_clock,            // host shift clock
   input  wire logic          serial_data_in,         // cascade input
   output logic               serial_data_out,        // serial word, msb first
   output logic               fine_sine_out,          // fine sine bit
   output logic               fine_cosine_out,        // fine cosine bit
   output logic               led_error_flag          // led regulation alarm
);
   localparam int PW = 17 + 2*SW;

   function automatic logic [15:0] aeg_g2b(input logic [15:0] g);
      logic [15:0] b;
      b[15] = g[15];
      for (int i = 14; i >= 0; i--)
         b[i] = b[i+1] ^ g[i];
      return b;
   endfunction : aeg_g2b

   function automatic logic [15:0] aeg_b2g(input logic [15:0] b);
      return b ^ (b >> 1);
   endfunction : aeg_b2g

   // pins leave reset at their idle level: load select high (pulled up), so no false
   // load->shift event is seen in the cycle after reset
   localparam logic [PW-1:0] PIN_IDLE = PW'(3'h4);

   // two-flop synchroniser for every pin
   logic [PW-1:0] pin_meta_r;
   logic [PW-1:0] pin_s_r;
   wire  logic [PW-1:0] pin_raw = {coarse_track_bits, sine_channel, cosine_channel, led_drive_above_half,
                                   gray_correction_enable, msb_invert, shift_load_select, shift_clock,
                                   serial_data_in};
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         pin_meta_r <= PIN_IDLE;
         pin_s_r    <= PIN_IDLE;
      end
      else
      begin
         pin_meta_r <= pin_raw;
         pin_s_r    <= pin_meta_r;
      end
   end

   wire logic [10:0]   coarse_s = pin_s_r[PW-1 -: 11];
   wire logic [SW-1:0] sine_s   = pin_s_r[6+2*SW-1 -: SW];
   wire logic [SW-1:0] cos_s    = pin_s_r[6+SW-1 -: SW];
   wire logic          led_s    = pin_s_r[5];
   wire logic          corr_s   = pin_s_r[4];
   wire logic          inv_s    = pin_s_r[3];
   wire logic          load_s   = pin_s_r[2];
   wire logic          scl_s    = pin_s_r[1];
   wire logic          din_s    = pin_s_r[0];

   aeg_quad_t  quad;
   logic [3:0] interp;
   logic       sine_bit;

   aeg_interp #(.SW(SW)) u_interp (
      .clk             (clk),
      .rst_n           (rst_n),
      .sine_smp        (sine_s),
      .cosine_smp      (cos_s),
      .quadrant_r      (quad),
      .interp_r        (interp),
      .fine_sine_bit   (sine_bit),
      .fine_cosine_bit (fine_cosine_out)
   );
   assign fine_sine_out = sine_bit;

   // uncorrected: coarse tracks above the fine sine bit, interpolation below
   wire logic [15:0] raw_up   = aeg_g2b({coarse_s, sine_bit, 4'h0});
   wire logic [15:0] bin_raw  = {raw_up[15:4], interp};
   // corrected: fine quadrant is trusted, coarse bin bits 10:1 only pick the period
   wire logic [15:0] crs_bin  = aeg_g2b({coarse_s, 5'h00});
   wire logic        mism     = crs_bin[5] ^ quad[1];
   wire logic        up_inc   = mism & (quad == 2'h0);
   wire logic        up_dec   = mism & (quad == 2'h3);
   wire logic [9:0]  up_corr  = crs_bin[15:6] + {9'h000, up_inc} - {9'h000, up_dec};
   wire logic [15:0] bin_corr = {up_corr, quad, interp};
   // coarse tracks switch within a quadrant of the fine edges, so one step keeps it monotonic
   wire logic [15:0] gray_nxt = corr_s ? aeg_b2g(bin_corr) : aeg_b2g(bin_raw);
   wire logic [15:0] word_nxt = gray_nxt ^ {inv_s, 15'h0000};

   logic [15:0] pos_word_r;
   logic        inv_used_r;
   logic [15:0] shreg_r;
   logic [4:0]  cnt_r;
   logic        scl_d_r;
   logic        led_d_r;
   aeg_state_t  state_r;
   aeg_state_t  state_nxt;
   logic        ctrl_freeze_r;
   logic [15:0] pos_snap_r;
   aeg_evt_t    status_r;
   aeg_evt_t    mask_r;
   logic        ack_r;
   logic [31:0] rdata_r;
   logic        irq_r;

   wire logic scl_rise = scl_s & ~scl_d_r;
   wire logic shift_go = ~load_s & scl_rise;
   wire logic last_bit = shift_go & (cnt_r == `AEG_WORD_LEN - 5'h01);

   always_comb
   begin
      state_nxt = state_r;
      unique case (state_r)
         AEG_ST_LOAD  : if (!load_s) state_nxt = AEG_ST_SHIFT;
         AEG_ST_SHIFT : if (load_s) state_nxt = AEG_ST_LOAD;
                        else if (last_bit) state_nxt = AEG_ST_SPENT;
         AEG_ST_SPENT : if (load_s) state_nxt = AEG_ST_LOAD;
      endcase
   end

   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         pos_word_r <= `AEG_RST_WORD;
         inv_used_r <= 1'b0;
         scl_d_r    <= 1'b0;
         led_d_r    <= 1'b0;
         state_r    <= AEG_ST_LOAD;
      end
      else
      begin
         pos_word_r <= word_nxt;
         inv_used_r <= inv_s;
         scl_d_r    <= scl_s;
         led_d_r    <= led_s;
         state_r    <= state_nxt;
      end
   end

   // snapshot refreshed every cycle in load mode, then frozen for the frame
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         shreg_r <= `AEG_RST_WORD;
         cnt_r   <= 5'h00;
      end
      else if (load_s)
      begin
         shreg_r <= pos_word_r;
         cnt_r   <= 5'h00;
      end
      else if (shift_go)
      begin
         shreg_r <= {shreg_r[14:0], din_s};
         cnt_r   <= (cnt_r == `AEG_WORD_LEN) ? cnt_r : cnt_r + 5'h01;
      end
   end

   assign serial_data_out = shreg_r[15];
   assign led_error_flag  = led_d_r;

   // register slave: request held, answered on the second edge
   wire logic     acc      = avs_read | avs_write;
   wire logic     wr_go    = avs_write & ack_r & avs_byteenable[0];
   wire logic     hit_ctrl = avs_address == `AEG_OFS_CTRL;
   wire logic     hit_pos  = avs_address == `AEG_OFS_POS;
   wire logic     hit_stat = avs_address == `AEG_OFS_STATUS;
   wire logic     hit_mask = avs_address == `AEG_OFS_MASK;
   wire logic     hit_pins = avs_address == `AEG_OFS_PINS;
   wire aeg_evt_t w1c      = (wr_go & hit_stat) ? avs_writedata[2:0] : 3'h0;
   wire aeg_evt_t ev;
   assign ev[`AEG_EV_LED]  = led_s & ~led_d_r;
   assign ev[`AEG_EV_LOAD] = (state_r == AEG_ST_LOAD) & ~load_s;
   assign ev[`AEG_EV_DONE] = last_bit;
   wire logic [31:0] pins_rd = {24'h000000, 1'b0, state_r == AEG_ST_SPENT, corr_s, inv_s, load_s,
                                led_d_r, fine_cosine_out, sine_bit};
   wire logic [31:0] rd_mux  = hit_ctrl ? {31'h00000000, ctrl_freeze_r} :
                               hit_pos  ? {16'h0000, pos_snap_r} :
                               hit_stat ? {29'h00000000, status_r} :
                               hit_mask ? {29'h00000000, mask_r} :
                               hit_pins ? pins_rd : 32'h00000000;

   assign avs_waitrequest = acc & ~ack_r;
   assign avs_readdata    = rdata_r;
   assign irq             = irq_r;

   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         ack_r         <= 1'b0;
         rdata_r       <= 32'h00000000;
         ctrl_freeze_r <= `AEG_RST_CTRL;
         mask_r        <= `AEG_RST_EVT;
         status_r      <= `AEG_RST_EVT;
         pos_snap_r    <= `AEG_RST_WORD;
         irq_r         <= 1'b0;
      end
      else
      begin
         ack_r <= acc & ~ack_r;
         if (avs_read & ~ack_r)
            rdata_r <= rd_mux;
         if (wr_go & hit_ctrl)
            ctrl_freeze_r <= avs_writedata[`AEG_CTRL_FREEZE];
         if (wr_go & hit_mask)
            mask_r <= avs_writedata[2:0];
         // a new event beats a clear in the same cycle
         status_r <= (status_r & ~w1c) | ev;
         if (!ctrl_freeze_r)
            pos_snap_r <= pos_word_r;
         irq_r <= |((status_r & ~w1c | ev) & mask_r);
      end
   end

   wire logic [15:0] chk_bin = aeg_g2b(pos_word_r ^ {inv_used_r, 15'h0000});

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_n);

   chk_load_msb_out: assert property (load_s ##1 load_s |-> serial_data_out == $past(pos_word_r[15]))
      else $error("load mode msb not at serial output");
   chk_shift_advance: assert property (shift_go |=> serial_data_out == $past(shreg_r[14]))
      else $error("shift did not present next bit");
   chk_cascade_in: assert property (shift_go |=> shreg_r[0] == $past(din_s))
      else $error("serial input not shifted in");
   chk_snapshot_hold: assert property (!load_s && !scl_rise |=> $stable(shreg_r))
      else $error("snapshot changed without a shift edge");
   chk_msb_flip: assert property (##1 pos_word_r[15] == ($past(gray_nxt[15]) ^ $past(inv_s)))
      else $error("msb invert not applied");
   chk_low_bits_kept: assert property (##2 chk_bin[3:0] == $past(interp))
      else $error("interpolated bits altered");
   chk_corr_off_raw: assert property (!corr_s |=> pos_word_r[14:5] == $past(coarse_s[9:0]))
      else $error("raw coarse bits not passed");
   chk_corr_aligned: assert property (corr_s |=> chk_bin[5:4] == $past(quad))
      else $error("coarse bits not aligned to fine quadrant");
   chk_led_alarm: assert property ($rose(led_s) |=> led_error_flag)
      else $error("led error flag missed");
   chk_rise_only: assert property (!load_s && $rose(scl_s) |=> shreg_r[15:1] == $past(shreg_r[14:0]))
      else $error("shift did not follow the rising shift clock");
   chk_bus_answer: assert property (acc |-> ##[0:1] !avs_waitrequest)
      else $error("bus answer late");
   // a pending unmasked event keeps the line up until software clears it
   chk_irq_level: assert property (|(status_r & mask_r) && !wr_go |=> irq)
      else $error("interrupt not raised for pending event");
   chk_status_sticky: assert property (status_r[`AEG_EV_DONE] && !wr_go |=> status_r[`AEG_EV_DONE])
      else $error("status bit lost without a clear");
   chk_load_no_shift: assert property (load_s |=> cnt_r == 5'h00)
      else $error("bit count not held in load mode");

   cov_frame_start: cover property (load_s ##1 !load_s);
   cov_word_done:   cover property (last_bit);
   cov_led_event:   cover property ($rose(led_error_flag));
   cov_irq_raised:  cover property ($rose(irq));
   cov_corr_step:   cover property (corr_s && (up_inc || up_dec));
endmodule : aeg_encoder

// ==== rtl/aeg_interp.sv ====
// Purpose: quadrant and 1/16-quadrant interpolation of conditioned sine/cosine samples
// Assumes: samples already synchronised to clk, two's complement
// Notes: arctangent by comparison against a fixed tangent table
`timescale 1ns/1ps
`include "aeg_regs.svh"
module aeg_interp
   import aeg_pkg::*;
#(
   parameter int SW = 12
)
(
   input  wire logic          clk,             // system clock
   input  wire logic          rst_n,           // synchronous reset
   input  wire logic [SW-1:0] sine_smp,        // conditioned sine sample
   input  wire logic [SW-1:0] cosine_smp,      // conditioned cosine sample
   output aeg_quad_t          quadrant_r,      // binary quadrant of the period
   output logic      [3:0]    interp_r,        // interpolated bits, binary
   output logic               fine_sine_bit,   // digitised fine bit, gray lsb
   output logic               fine_cosine_bit  // digitised quadrature bit
);
   // tan(k*90/16) scaled by 2**8, k = 1..15
   localparam logic [11:0] TAN [15] = '{12'h019, 12'h033, 12'h04E, 12'h06A, 12'h089,
      12'h0AB, 12'h0D2, 12'h100, 12'h138, 12'h17F, 12'h1DF, 12'h26A, 12'h34C,
      12'h507, 12'hA27};

   function automatic logic [3:0] aeg_steps(input logic [SW-1:0] num, input logic [SW-1:0] den);
      logic [3:0] n;
      n = 4'h0;
      for (int i = 0; i < 15; i++)
         if ((SW+12)'({num, 8'h00}) >= (SW+12)'(den * TAN[i]))
            n = n + 4'h1;
      return n;
   endfunction : aeg_steps

   function automatic logic [SW-1:0] aeg_abs(input logic [SW-1:0] v);
      return v[SW-1] ? SW'(-v) : v;
   endfunction : aeg_abs

   wire logic            sin_neg = sine_smp[SW-1];
   wire logic            cos_neg = cosine_smp[SW-1];
   wire aeg_quad_t       quad_w  = {sin_neg, sin_neg ^ cos_neg};
   wire logic [SW-1:0]   sin_mag = aeg_abs(sine_smp);
   wire logic [SW-1:0]   cos_mag = aeg_abs(cosine_smp);
   // odd quadrants measure the angle from the other axis, so the ratio flips
   wire logic [3:0]      step_w  = quad_w[0] ? aeg_steps(cos_mag, sin_mag) : aeg_steps(sin_mag, cos_mag);

   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         quadrant_r      <= 2'h0;
         interp_r        <= 4'h0;
         fine_sine_bit   <= 1'b0;
         fine_cosine_bit <= 1'b0;
      end
      else
      begin
         quadrant_r      <= quad_w;
         interp_r        <= step_w;
         fine_sine_bit   <= quad_w[1] ^ quad_w[0];
         fine_cosine_bit <= quad_w[1];
      end
   end
endmodule : aeg_interp

// ==== rtl/aeg_pkg.sv ====
// Purpose: shared types of the encoder back end
// Assumes: nothing
// Notes: constants live in aeg_regs.svh
package aeg_pkg;
   typedef enum logic [1:0] {AEG_ST_LOAD, AEG_ST_SHIFT, AEG_ST_SPENT} aeg_state_t;
   typedef logic [1:0] aeg_quad_t;
   typedef logic [2:0] aeg_evt_t;
endpackage : aeg_pkg

// ==== rtl/aeg_regs.svh ====
// Purpose: offsets, field positions, reset values and counts of the encoder back end
// Assumes: byte addresses of 32-bit words
// Notes: definitions only
`ifndef AEG_REGS_SVH
`define AEG_REGS_SVH
`define AEG_OFS_CTRL    8'h00
`define AEG_OFS_POS     8'h04
`define AEG_OFS_STATUS  8'h08
`define AEG_OFS_MASK    8'h0C
`define AEG_OFS_PINS    8'h10
`define AEG_CTRL_FREEZE 0
`define AEG_EV_LED      0
`define AEG_EV_LOAD     1
`define AEG_EV_DONE     2
`define AEG_RST_CTRL    1'h0
`define AEG_RST_EVT     3'h0
`define AEG_RST_WORD    16'h0000
`define AEG_WORD_LEN    5'h10
`define AEG_TAN_SHIFT   8
`endif

// ==== verif/aeg_encoder_bench.sv ====
// Purpose: self-checking bench of the encoder back end
// Assumes: correction off unless a test says otherwise
// Notes: upper 12 bits are predicted, low 4 follow the position register
`timescale 1ns/1ps
`include "aeg_regs.svh"
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin mismatches++; \
   $display("CHECK FAILED %s expected %h seen %h", n, e, g); end end
module aeg_encoder_bench;
   import aeg_pkg::*;
   logic        clk, rst_n, avs_read, avs_write, avs_waitrequest, irq;
   logic [7:0]  avs_address;
   logic [31:0] avs_writedata, avs_readdata, q, p0;
   logic [3:0]  avs_byteenable;
   logic [10:0] coarse;
   logic [11:0] sine, cosine, exp_top;
   logic        led, corr, inv, sl, sc, sdi, sdo, fso, fco, lef, cs;
   logic [15:0] w;
   int          mismatches, cmp_count, i, n;
   logic [7:0]  zero_ofs [4] = '{8'h00, 8'h08, 8'h0C, 8'h1C};

   aeg_encoder #(.SW(12)) uut (.clk(clk), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .irq(irq),
      .coarse_track_bits(coarse), .sine_channel(sine), .cosine_channel(cosine),
      .led_drive_above_half(led), .gray_correction_enable(corr), .msb_invert(inv),
      .shift_load_select(sl), .shift_clock(sc), .serial_data_in(sdi), .serial_data_out(sdo),
      .fine_sine_out(fso), .fine_cosine_out(fco), .led_error_flag(lef));
   aeg_host_model host (.serial_data_out(sdo), .shift_load_select(sl), .shift_clock(sc),
      .serial_data_in(sdi));

   task automatic results;
      $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
      if (mismatches == 0 && cmp_count > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : results

   // holds the request until waitrequest is seen low at a rising edge
   task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic [3:0] be);
      int k;
      @(posedge clk);
      avs_address <= a;
      avs_writedata <= d;
      avs_byteenable <= be;
      avs_read <= ~wr;
      avs_write <= wr;
      k = 0;
      do
      begin
         @(posedge clk);
         k++;
      end
      while (avs_waitrequest !== 1'b0 && k < 20);
      if (avs_waitrequest !== 1'b0)
      begin
         mismatches++;
         results();
      end
      q = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
   endtask : bus

   // upper 12 gray bits: coarse tracks, then the fine bit of the quadrant
   function automatic logic [11:0] top12(input logic [10:0] t, input logic sn, input logic cn, input logic iv);
      logic [1:0] qd;
      qd = {sn, sn ^ cn};
      return {t[10] ^ iv, t[9:0], qd[1] ^ qd[0]};
   endfunction : top12

   // corrected upper 12 bits: coarse binary lsb must agree with the fine quadrant msb
   function automatic logic [11:0] ctop12(input logic [10:0] t, input logic sn, input logic cn, input logic iv);
      logic [10:0] cb;
      logic [1:0]  qd;
      logic [11:0] b;
      cb[10] = t[10];
      for (int k = 9; k >= 0; k--)
         cb[k] = cb[k+1] ^ t[k];
      qd = {sn, sn ^ cn};
      b = {cb[10:1], qd};
      if (cb[0] != qd[1] && qd == 2'h0)
         b[11:2] = cb[10:1] + 10'h001;
      if (cb[0] != qd[1] && qd == 2'h3)
         b[11:2] = cb[10:1] - 10'h001;
      return (b ^ (b >> 1)) ^ {iv, 11'h000};
   endfunction : ctop12

   // binary value of the four interpolated bits of a 16-bit gray word
   function automatic logic [3:0] bin_low(input logic [15:0] g);
      logic [3:0] b;
      b[3] = ^g[15:3];
      b[2] = b[3] ^ g[2];
      b[1] = b[2] ^ g[1];
      b[0] = b[1] ^ g[0];
      return b;
   endfunction : bin_low

   initial
   begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   initial
   begin
      #500000;
      mismatches++;
      results();
   end

   initial
   begin
      {rst_n, avs_read, avs_write, avs_address, avs_writedata, avs_byteenable} = '0;
      {coarse, sine, cosine, led, corr, inv} = '0;
      void'($urandom(32'hded1));
      repeat (8) @(posedge clk);
      rst_n <= 1'b1;
      repeat (3) @(posedge clk);
      foreach (zero_ofs[j])
      begin
         bus(1'b0, zero_ofs[j], 32'h0, 4'hF);
         `CHK("reset_or_unmapped", 32'h0, q)
      end
      $display("test reset done");

      for (i = 0; i < 6; i++)
      begin
         @(posedge clk);
         coarse <= 11'($urandom);
         sine <= 12'($urandom);
         cosine <= 12'($urandom);
         inv <= i[0];
         repeat (12) @(posedge clk);
         #1;
         exp_top = top12(coarse, sine[11], cosine[11], inv);
         `CHK("fine_cosine", sine[11], fco)
         `CHK("fine_sine", exp_top[0], fso)
         bus(1'b0, `AEG_OFS_POS, 32'h0, 4'hF);
         `CHK("pos_top", exp_top, q[15:4])
         // the tracks move mid-frame; the snapshot must not
         fork
            host.frame(i[1], w, cs);
            begin
               #600;
               @(posedge clk);
               coarse <= ~coarse;
            end
         join
         `CHK("frame_top", exp_top, w[15:4])
         `CHK("frame_low", q[3:0], w[3:0])
         `CHK("cascade", i[1], cs)
         bus(1'b0, `AEG_OFS_STATUS, 32'h0, 4'hF);
         `CHK("frame_events", 2'b11, q[2:1])
         bus(1'b1, `AEG_OFS_STATUS, 32'h7, 4'h1);
      end
      $display("test frames done");

      bus(1'b0, `AEG_OFS_POS, 32'h0, 4'hF);
      p0 = q;
      @(posedge clk);
      corr <= 1'b1;
      repeat (12) @(posedge clk);
      bus(1'b0, `AEG_OFS_POS, 32'h0, 4'hF);
      // gray low bits follow the parity of the upper code, so the interpolation is compared in binary
      `CHK("corr_low", bin_low(p0[15:0]), bin_low(q[15:0]))
      `CHK("corr_top", ctop12(coarse, sine[11], cosine[11], inv), q[15:4])
      // freeze holds the position register while the tracks move
      p0 = q;
      bus(1'b1, `AEG_OFS_CTRL, 32'h1, 4'h1);
      @(posedge clk);
      coarse <= ~coarse;
      repeat (12) @(posedge clk);
      bus(1'b0, `AEG_OFS_POS, 32'h0, 4'hF);
      `CHK("pos_frozen", p0, q)
      bus(1'b1, `AEG_OFS_CTRL, 32'h0, 4'h1);
      repeat (3) @(posedge clk);
      bus(1'b0, `AEG_OFS_POS, 32'h0, 4'hF);
      `CHK("corr_top_moved", ctop12(coarse, sine[11], cosine[11], inv), q[15:4])
      $display("test correction done");

      bus(1'b1, `AEG_OFS_MASK, 32'h1, 4'h0);
      bus(1'b0, `AEG_OFS_MASK, 32'h0, 4'hF);
      `CHK("mask_no_lane", 32'h0, q)
      bus(1'b1, `AEG_OFS_MASK, 32'h1, 4'h1);
      @(posedge clk);
      led <= 1'b1;
      n = 0;
      do
      begin
         @(posedge clk);
         #1;
         n++;
      end
      while (irq !== 1'b1 && n < 20);
      `CHK("irq_set", 1'b1, irq)
      `CHK("led_flag", 1'b1, lef)
      @(posedge clk);
      led <= 1'b0;
      repeat (6) @(posedge clk);
      bus(1'b1, `AEG_OFS_STATUS, 32'h1, 4'h1);
      repeat (3) @(posedge clk);
      #1;
      `CHK("irq_clear", 1'b0, irq)
      `CHK("led_flag_off", 1'b0, lef)
      $display("test led alarm done");
      results();
   end
endmodule : aeg_encoder_bench

// ==== verif/aeg_host_model.sv ====
// Purpose: host that loads and clocks out the serial position word
// Assumes: 8 MHz shift clock that stands low outside frames
// Notes: each bit is taken in the middle of the low phase
`timescale 1ns/1ps
module aeg_host_model
(
   input  wire logic serial_data_out,   // device serial output
   output logic      shift_load_select, // 1 load, 0 shift
   output logic      shift_clock,       // host shift clock
   output logic      serial_data_in     // cascade bit
);
   initial
   begin
      shift_load_select = 1'b1;
      shift_clock       = 1'b0;
      serial_data_in    = 1'b0;
   end
   // msb is read in load mode, 15 bits follow, then the cascade bit
   task automatic frame(input logic cas, output logic [15:0] w, output logic cas_seen);
      int k;
      // step off the clk edge that the caller returned on
      #1;
      serial_data_in = cas;
      shift_load_select = 1'b1;
      #100;
      w[15] = serial_data_out;
      shift_load_select = 1'b0;
      #61.5;
      for (k = 1; k <= 16; k++)
      begin
         shift_clock = 1'b1;
         #62.5;
         shift_clock = 1'b0;
         #31;
         if (k < 16)
            w[15-k] = serial_data_out;
         else
            cas_seen = serial_data_out;
         #31.5;
      end
      // all 16 bits are used: the snapshot holds while the tracks move in the bench
      shift_load_select = 1'b1;
      serial_data_in = ~cas;
   endtask : frame
endmodule : aeg_host_model
